/* core/pmt_pkg.sv */
// Constants, register map and helpers for the period match timer
//
// Overview of operation
// R1: Count climbs to period, then wraps to zero
// R2: Period is read/write, resets to all ones
// R3: Prescale select: 00 /1, 01 /4, 1x /16
// R4: Postscaler ratio select+1 sets match flag
// R5: Run bit enables counting; off stops timer
// R6: Count or control write clears both scalers
// R7: Control write leaves the count unchanged
// R8: Count is read/write, resets to zero
// R9: Control bit 7 unimplemented, reads zero
// R10: Period match drives the PWM time base
// R11: Serial port gets match before postscaler
// R12: Flag sticky; request needs flag and enable
// R13: All scaling runs on instruction clock ticks
package pmt_pkg;

   // ----------------------------------------------------------------
   // Bus and register map
   // ----------------------------------------------------------------
   localparam int PMT_ADDR_W = 12;
   localparam logic [11:0] PMT_OFF_COUNT = 12'h000;
   localparam logic [11:0] PMT_OFF_PERIOD = 12'h004;
   localparam logic [11:0] PMT_OFF_CONTROL = 12'h008;
   localparam logic [11:0] PMT_OFF_STATUS = 12'h00c;
   localparam logic [11:0] PMT_OFF_MASK = 12'h010;

   typedef enum logic [2:0] {
      PMT_REG_COUNT,
      PMT_REG_PERIOD,
      PMT_REG_CONTROL,
      PMT_REG_STATUS,
      PMT_REG_MASK,
      PMT_REG_NONE
   } pmt_reg_e;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int PMT_CTL_PRE_LSB = 0;
   localparam int PMT_CTL_RUN_BIT = 2;
   localparam int PMT_CTL_POST_LSB = 3;
   localparam int PMT_STAT_FLAG_BIT = 0;
   localparam int PMT_STAT_RUN_BIT = 1;
   localparam logic [7:0] PMT_COUNT_RST = 8'h00;
   localparam logic [7:0] PMT_PERIOD_RST = 8'hff;
   localparam logic [6:0] PMT_CTRL_RST = 7'h00;

   // ----------------------------------------------------------------
   // Timing: instruction clock is the core clock divided by four
   // ----------------------------------------------------------------
   localparam logic [1:0] PMT_PHASE_LAST = 2'h3;
   localparam logic [3:0] PMT_PRE_LAST_1 = 4'h0;
   localparam logic [3:0] PMT_PRE_LAST_4 = 4'h3;
   localparam logic [3:0] PMT_PRE_LAST_16 = 4'hf;

   function automatic logic [3:0] pmt_pre_last(input logic [1:0] sel);
      logic [3:0] r;
      r = PMT_PRE_LAST_16;
      if (sel == 2'h0) begin
         r = PMT_PRE_LAST_1;
      end else if (sel == 2'h1) begin
         r = PMT_PRE_LAST_4;
      end
      return r;
   endfunction : pmt_pre_last

   function automatic pmt_reg_e pmt_decode(input logic [11:0] a);
      pmt_reg_e r;
      unique case (a)
         PMT_OFF_COUNT: r = PMT_REG_COUNT;
         PMT_OFF_PERIOD: r = PMT_REG_PERIOD;
         PMT_OFF_CONTROL: r = PMT_REG_CONTROL;
         PMT_OFF_STATUS: r = PMT_REG_STATUS;
         PMT_OFF_MASK: r = PMT_REG_MASK;
         default: r = PMT_REG_NONE;
      endcase
      return r;
   endfunction : pmt_decode

endpackage : pmt_pkg

/* core/pmt_scale_if.sv */
// Interface between the timer core and its pre/post scalers
`timescale 1ns/10ps
interface pmt_scale_if;
   logic clr;
   logic run;
   logic [1:0] pre_sel;
   logic [3:0] post_sel;
   logic tick;
   logic match;
   logic post_evt;
   modport ctl(output clr, output run, output pre_sel, output post_sel, output match,
               input tick, input post_evt);
   modport pre(input clr, input run, input pre_sel, output tick);
   modport post(input clr, input match, input post_sel, output post_evt);
endinterface : pmt_scale_if

/* core/pmt_prescaler.sv */
// Instruction clock divider and selectable prescaler
`timescale 1ns/10ps
module pmt_prescaler (
   input wire logic clk,
   input wire logic rst,
   pmt_scale_if.pre sc
);
   import pmt_pkg::*;

   typedef struct packed {
      logic [1:0] phase;
      logic [3:0] pcnt;
   } pmt_pre_s;

   pmt_pre_s s_q;
   pmt_pre_s s_d;
   logic last_phase;
   logic [3:0] lim;

   assign last_phase = (s_q.phase == PMT_PHASE_LAST);
   assign lim = pmt_pre_last(sc.pre_sel);
   // A clearing write also swallows a tick due in the same cycle
   assign sc.tick = sc.run && !sc.clr && last_phase && (s_q.pcnt >= lim); // see R3 see R13

   always_comb begin
      s_d = s_q;
      if (sc.clr) begin
         s_d = '0; // see R6
      end else if (sc.run) begin
         s_d.phase = s_q.phase + 2'h1; // see R13
         if (last_phase) begin
            s_d.pcnt = (s_q.pcnt >= lim) ? 4'h0 : s_q.pcnt + 4'h1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_pre_spacing: assert property (sc.tick |=> !sc.tick [*3]) // see R13
      else $error("instruction ticks closer than four clocks");
   chk_pre_clear: assert property (sc.clr |=> s_q.phase == 2'h0 && s_q.pcnt == 4'h0) // see R6
      else $error("prescaler not cleared");
   chk_pre_stop: assert property (!sc.run |-> !sc.tick) // see R5
      else $error("tick while stopped");

endmodule : pmt_prescaler

/* core/pmt_postscaler.sv */
// Match postscaler producing the flag event
`timescale 1ns/10ps
module pmt_postscaler (
   input wire logic clk,
   input wire logic rst,
   pmt_scale_if.post sc
);
   import pmt_pkg::*;

   typedef struct packed {
      logic [3:0] cnt;
   } pmt_post_s;

   pmt_post_s s_q;
   pmt_post_s s_d;

   // Compare with >= so a ratio lowered mid-run cannot stall past wrap
   assign sc.post_evt = sc.match && !sc.clr && (s_q.cnt >= sc.post_sel); // see R4

   always_comb begin
      s_d = s_q;
      if (sc.clr) begin
         s_d.cnt = 4'h0; // see R6
      end else if (sc.match) begin
         s_d.cnt = sc.post_evt ? 4'h0 : s_q.cnt + 4'h1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_post_event: assert property (sc.post_evt |-> sc.match) // see R4
      else $error("postscaler event without a match");
   chk_post_unity: assert property (sc.match && !sc.clr && sc.post_sel == 4'h0 |-> sc.post_evt) // see R4
      else $error("ratio 1:1 missed a match");
   chk_post_clear: assert property (sc.clr |=> s_q.cnt == 4'h0) // see R6
      else $error("postscaler not cleared");

endmodule : pmt_postscaler

/* core/pmt_timer.sv */
// Period match timer top: AHB-Lite registers, count, compare, interrupt
//
// Decided for this implementation: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
module pmt_timer #(
   parameter int ADDR_W = pmt_pkg::PMT_ADDR_W
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic irq,
   output logic pwm_timebase,
   output logic ssp_shift_tick
);
   import pmt_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] count;
      logic [7:0] period;
      logic [6:0] ctrl;
      logic flag;
      logic mask;
      logic dp_valid;
      logic dp_write;
      pmt_reg_e dp_reg;
      logic [31:0] rdata;
      logic match;
   } pmt_main_s;

   pmt_main_s s_q;
   pmt_main_s s_d;

   pmt_scale_if sc ();

   logic addr_take;
   pmt_reg_e addr_reg;
   logic wr_count;
   logic wr_period;
   logic wr_ctrl;
   logic wr_status;
   logic wr_mask;
   logic at_period;
   logic wrap;

   // ----------------------------------------------------------------
   // Scalers
   // ----------------------------------------------------------------
   pmt_prescaler u_pre (
      .clk(clk),
      .rst(rst),
      .sc(sc.pre)
   );

   pmt_postscaler u_post (
      .clk(clk),
      .rst(rst),
      .sc(sc.post)
   );

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // Zero wait states: every transfer finishes in its first data cycle
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_q.rdata;

   // Only whole words are expected; hsize is accepted but not checked
   assign addr_take = hsel && htrans[1] && hready;
   assign addr_reg = pmt_decode(haddr[11:0]);

   assign wr_count = s_q.dp_valid && s_q.dp_write && (s_q.dp_reg == PMT_REG_COUNT);
   assign wr_period = s_q.dp_valid && s_q.dp_write && (s_q.dp_reg == PMT_REG_PERIOD);
   assign wr_ctrl = s_q.dp_valid && s_q.dp_write && (s_q.dp_reg == PMT_REG_CONTROL);
   assign wr_status = s_q.dp_valid && s_q.dp_write && (s_q.dp_reg == PMT_REG_STATUS);
   assign wr_mask = s_q.dp_valid && s_q.dp_write && (s_q.dp_reg == PMT_REG_MASK);

   // ----------------------------------------------------------------
   // Scaler control
   // ----------------------------------------------------------------
   assign sc.clr = wr_count || wr_ctrl; // see R6
   assign sc.run = s_q.ctrl[PMT_CTL_RUN_BIT]; // see R5
   assign sc.pre_sel = s_q.ctrl[PMT_CTL_PRE_LSB +: 2]; // see R3
   assign sc.post_sel = s_q.ctrl[PMT_CTL_POST_LSB +: 4]; // see R4

   // Compare is evaluated only on a prescaled tick; a count write wins
   assign at_period = (s_q.count == s_q.period);
   assign wrap = sc.tick && !wr_count && at_period; // see R1 see R13
   assign sc.match = wrap;

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign pwm_timebase = s_q.match; // see R10
   assign ssp_shift_tick = s_q.match; // see R11
   assign irq = s_q.flag && s_q.mask; // see R12

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.match = wrap;

      // Counter; writes take precedence over a tick in the same cycle
      if (wr_count) begin
         s_d.count = hwdata[7:0]; // see R8
      end else if (sc.tick) begin
         s_d.count = at_period ? PMT_COUNT_RST : s_q.count + 8'h01; // see R1
      end

      if (wr_period) begin
         s_d.period = hwdata[7:0]; // see R2
      end

      // Bit 7 is not stored, so it always reads back as zero
      if (wr_ctrl) begin
         s_d.ctrl = hwdata[6:0]; // see R7 see R9
      end

      if (wr_mask) begin
         s_d.mask = hwdata[PMT_STAT_FLAG_BIT];
      end

      // Hardware set beats a simultaneous write-one clear
      if (wr_status && hwdata[PMT_STAT_FLAG_BIT]) begin
         s_d.flag = 1'b0;
      end
      if (sc.post_evt) begin
         s_d.flag = 1'b1; // see R4 see R12
      end

      // Address phase capture
      s_d.dp_valid = addr_take;
      s_d.dp_write = addr_take && hwrite;
      s_d.dp_reg = addr_take ? addr_reg : PMT_REG_NONE;

      // Read data is taken from next values so a write just before is seen
      if (addr_take && !hwrite) begin
         unique case (addr_reg)
            PMT_REG_COUNT: s_d.rdata = {24'h00_0000, s_d.count};
            PMT_REG_PERIOD: s_d.rdata = {24'h00_0000, s_d.period};
            PMT_REG_CONTROL: s_d.rdata = {24'h00_0000, 1'b0, s_d.ctrl}; // see R9
            PMT_REG_STATUS: s_d.rdata = {30'h0000_0000, s_d.ctrl[PMT_CTL_RUN_BIT], s_d.flag};
            PMT_REG_MASK: s_d.rdata = {31'h0000_0000, s_d.mask};
            default: s_d.rdata = 32'h0000_0000;
         endcase
      end else begin
         s_d.rdata = 32'h0000_0000;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q.count <= PMT_COUNT_RST; // see R8
         s_q.period <= PMT_PERIOD_RST; // see R2
         s_q.ctrl <= PMT_CTRL_RST;
         s_q.flag <= 1'b0;
         s_q.mask <= 1'b0;
         s_q.dp_valid <= 1'b0;
         s_q.dp_write <= 1'b0;
         s_q.dp_reg <= PMT_REG_NONE;
         s_q.rdata <= 32'h0000_0000;
         s_q.match <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_wrap_tick;
      sc.tick && !wr_count && at_period;
   endsequence

   sequence s_step_tick;
      sc.tick && !wr_count && !at_period;
   endsequence

   chk_count_wrap: assert property (s_wrap_tick |=> s_q.count == 8'h00 && pwm_timebase) // see R1
      else $error("count did not wrap at period");
   chk_count_step: assert property (s_step_tick |=> s_q.count == $past(s_q.count) + 8'h01) // see R1
      else $error("count did not advance by one");
   chk_count_idle: assert property (!sc.tick && !wr_count |=> $stable(s_q.count)) // see R5
      else $error("count moved without a tick");
   chk_count_write: assert property (wr_count |=> s_q.count == $past(hwdata[7:0])) // see R8
      else $error("count write lost");
   chk_period_write: assert property (wr_period |=> s_q.period == $past(hwdata[7:0])) // see R2
      else $error("period write lost");
   chk_ctrl_keeps: assert property (wr_ctrl && !wr_count |=> $stable(s_q.count)) // see R7
      else $error("control write disturbed count");
   chk_ctrl_msb: assert property (s_q.dp_valid && !s_q.dp_write && $past(addr_reg) == PMT_REG_CONTROL
                                  |-> hrdata[7] == 1'b0) // see R9
      else $error("unimplemented control bit read as one");
   chk_match_zero: assert property (pwm_timebase |-> s_q.count == 8'h00 && ssp_shift_tick) // see R10 see R11
      else $error("match pulse without a wrapped count");
   chk_flag_sticky: assert property (s_q.flag && !(wr_status && hwdata[0]) |=> s_q.flag) // see R12
      else $error("flag dropped without a clear");
   chk_irq_gate: assert property (irq |-> s_q.flag && s_q.mask) // see R12
      else $error("request without flag and enable");
   chk_flag_set: assert property (sc.post_evt |=> s_q.flag) // see R4 see R12
      else $error("postscaler event did not set the flag");
   chk_flag_clear: assert property (wr_status && hwdata[0] && !sc.post_evt |=> !s_q.flag) // see R12
      else $error("write-one clear did not drop the flag");
   chk_period_hold: assert property (!wr_period |=> $stable(s_q.period)) // see R2
      else $error("period changed without a write");
   chk_rdata_idle: assert property (!s_q.dp_valid || s_q.dp_write |-> hrdata == 32'h0000_0000)
      else $error("read data outside a read data phase");

endmodule : pmt_timer

/* test/period_match_timer_bench.sv */
// Self-checking bench for the period match timer over its AHB-Lite registers
`timescale 1ns/10ps
module period_match_timer_bench;
   import pmt_pkg::*;

   // ----------------------------------------------------------------
   // Stimulus and design hookup
   // ----------------------------------------------------------------
   logic clk;
   logic rst;
   logic hsel;
   logic hwrite;
   logic [11:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic irq;
   logic pwm_timebase;
   logic ssp_shift_tick;
   int n_fail = 0;
   int checked = 0;
   int n;

   pmt_timer u_dut (
      .clk(clk),
      .rst(rst),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hreadyout),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .irq(irq),
      .pwm_timebase(pwm_timebase),
      .ssp_shift_tick(ssp_shift_tick)
   );

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Bus and check tasks
   // ----------------------------------------------------------------
   task automatic final_report();
      if (n_fail == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Waits are unbounded here on purpose: the watchdog ends a hung bus
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      hsize <= 3'b010;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : bus

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      chk(what, exp, q);
      chk("hresp", 32'h0000_0000, {31'h0, hresp});
   endtask : rd

   // Counts clocks up to the next match pulse; both match outputs must agree
   task automatic wait_pulse(output int cnt);
      cnt = 0;
      do begin
         @(posedge clk);
         cnt++;
      end while (pwm_timebase !== 1'b1 && cnt < 3000);
      // A pulse that never comes runs the limit out and counts as a mismatch here
      chk("pwm_timebase", 32'h0000_0001, {31'h0, pwm_timebase});
      chk("ssp_shift_tick", 32'h0000_0001, {31'h0, ssp_shift_tick});
   endtask : wait_pulse

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 12'h000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd("count_rst", PMT_OFF_COUNT, 32'h0000_0000);
      rd("period_rst", PMT_OFF_PERIOD, 32'h0000_00ff);
      rd("control_rst", PMT_OFF_CONTROL, 32'h0000_0000);
      rd("status_rst", PMT_OFF_STATUS, 32'h0000_0000);
      rd("mask_rst", PMT_OFF_MASK, 32'h0000_0000);
      rd("unmapped", 12'h014, 32'h0000_0000);
      wr(PMT_OFF_PERIOD, 32'h0000_005a);
      rd("period_rw", PMT_OFF_PERIOD, 32'h0000_005a);
      wr(PMT_OFF_CONTROL, 32'h0000_00ff);
      rd("control_bit7", PMT_OFF_CONTROL, 32'h0000_007f);
      wr(PMT_OFF_CONTROL, 32'h0000_0000);
      wr(PMT_OFF_COUNT, 32'h0000_0033);
      rd("count_rw", PMT_OFF_COUNT, 32'h0000_0033);
      // Count write restarts the /16 prescaler: first tick lands 64 clocks later
      wr(PMT_OFF_PERIOD, 32'h0000_00ff);
      wr(PMT_OFF_CONTROL, 32'h0000_0006);
      repeat (20) @(posedge clk);
      wr(PMT_OFF_COUNT, 32'h0000_0010);
      repeat (55) @(posedge clk);
      rd("count_before_tick", PMT_OFF_COUNT, 32'h0000_0010);
      repeat (6) @(posedge clk);
      rd("count_after_tick", PMT_OFF_COUNT, 32'h0000_0011);
      wr(PMT_OFF_CONTROL, 32'h0000_0000);
      rd("count_ctl_write", PMT_OFF_COUNT, 32'h0000_0011);
      repeat (100) @(posedge clk);
      rd("count_stopped", PMT_OFF_COUNT, 32'h0000_0011);
      // Match interval is (period+1) ticks of 4*prescale clocks
      wr(PMT_OFF_PERIOD, 32'h0000_0003);
      for (int s = 0; s < 4; s++) begin
         wr(PMT_OFF_CONTROL, {29'h0, 1'b1, s[1:0]});
         wait_pulse(n);
         wait_pulse(n);
         chk("match_interval", 16 * (s == 0 ? 1 : (s == 1 ? 4 : 16)), n);
      end
      // Postscale 1:3 sets the flag on the third match only
      wr(PMT_OFF_CONTROL, 32'h0000_0000);
      wr(PMT_OFF_STATUS, 32'h0000_0001);
      rd("flag_w1c", PMT_OFF_STATUS, 32'h0000_0000);
      wr(PMT_OFF_PERIOD, 32'h0000_0007);
      wr(PMT_OFF_CONTROL, 32'h0000_0014);
      for (int k = 1; k <= 3; k++) begin
         wait_pulse(n);
         rd("post_flag", PMT_OFF_STATUS, {30'h0, 1'b1, k == 3});
      end
      chk("irq_masked", 32'h0000_0000, {31'h0, irq});
      wr(PMT_OFF_MASK, 32'h0000_0001);
      @(posedge clk);
      chk("irq_raised", 32'h0000_0001, {31'h0, irq});
      wr(PMT_OFF_CONTROL, 32'h0000_0000);
      rd("flag_sticky", PMT_OFF_STATUS, 32'h0000_0001);
      wr(PMT_OFF_STATUS, 32'h0000_0001);
      @(posedge clk);
      chk("irq_cleared", 32'h0000_0000, {31'h0, irq});
      rd("flag_cleared", PMT_OFF_STATUS, 32'h0000_0000);
      final_report();
   end

   // ----------------------------------------------------------------
   // Watchdog: the sequence needs well under 10000 clocks
   // ----------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      final_report();
   end

endmodule : period_match_timer_bench
